// [dv/fcd_dmac_tb.sv]
// Self-checking bench for the DMA controller
`timescale 1ns/1ps
module fcd_dmac_tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sel_n = 1'b1;
    logic        rw_in = 1'b1;
    logic [4:0]  addr_lo_in = 5'h00;
    logic [7:0]  data_in = 8'h00;
    logic [3:0]  periph_xfer_request = 4'h0;
    logic [7:0]  data_out;
    logic [4:0]  addr_lo_out;
    logic [10:0] addr_hi_out;
    logic        data_oe, addr_lo_oe, addr_hi_oe, rw_out, rw_oe, ack_hi;
    logic        ack_oe, stretch_dma_request_n, halt_dma_request_n;
    logic        bus_grant_in, chan_ack_sel_lo, xfer_strobe;
    logic        irq_n_or_block_end_n;
    logic        seen_str = 1'b0;
    logic        seen_halt = 1'b0;
    int          num_errors = 0;
    int          samples_checked = 0;

    fcd_dmac dut (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .data_in               (data_in),
        .data_out              (data_out),
        .data_oe               (data_oe),
        .addr_lo_in            (addr_lo_in),
        .addr_lo_out           (addr_lo_out),
        .addr_lo_oe            (addr_lo_oe),
        .addr_hi_out           (addr_hi_out),
        .addr_hi_oe            (addr_hi_oe),
        .rw_in                 (rw_in),
        .rw_out                (rw_out),
        .rw_oe                 (rw_oe),
        .select_n_or_chan_ack_sel_hi_in  (sel_n),
        .select_n_or_chan_ack_sel_hi_out (ack_hi),
        .select_n_or_chan_ack_sel_hi_oe  (ack_oe),
        .stretch_dma_request_n (stretch_dma_request_n),
        .halt_dma_request_n    (halt_dma_request_n),
        .bus_grant_in          (bus_grant_in),
        .periph_xfer_request   (periph_xfer_request),
        .chan_ack_sel_lo       (chan_ack_sel_lo),
        .xfer_strobe           (xfer_strobe),
        .irq_n_or_block_end_n  (irq_n_or_block_end_n)
    );
    fcd_grant_model grant (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .stretch_dma_request_n (stretch_dma_request_n),
        .halt_dma_request_n    (halt_dma_request_n),
        .bus_grant_in          (bus_grant_in)
    );

    always #20 core_clk = ~core_clk;

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sel_n <= 1'b0;
        rw_in <= 1'b0;
        addr_lo_in <= a;
        data_in <= d;
        @(posedge core_clk);
        sel_n <= 1'b1;
        rw_in <= 1'b1;
    endtask

    // Sampled right after the taking edge: a later refresh clears done
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sel_n <= 1'b0;
        addr_lo_in <= a;
        @(posedge core_clk);
        sel_n <= 1'b1;
        #1;
        chk("read data", {8'h00, e}, {8'h00, data_out});
        chk("read drive", 16'h0001, {15'h0, data_oe});
    endtask

    // Waits for one byte cycle; h tells which request pin is expected
    task automatic strobe(input logic [15:0] a, input logic [2:0] chrw,
                          input logic last, input logic h);
        repeat (40) begin
            @(posedge core_clk);
            #1;
            if (!stretch_dma_request_n) seen_str = 1'b1;
            if (!halt_dma_request_n) seen_halt = 1'b1;
            if (xfer_strobe === 1'b1) break;
        end
        chk("strobe", 16'h0001, {15'h0, xfer_strobe});
        chk("request pin", {14'h0, !h, h}, {14'h0, seen_str, seen_halt});
        chk("dma address", a, {addr_hi_out, addr_lo_out});
        chk("chan dir", {13'h0, chrw},
            {13'h0, ack_hi, chan_ack_sel_lo, rw_out});
        chk("block end", {15'h0, !last}, {15'h0, irq_n_or_block_end_n});
        chk("drivers", 16'h001e,
            {11'h0, addr_lo_oe, addr_hi_oe, rw_oe, ack_oe, data_oe});
        seen_str = 1'b0;
        seen_halt = 1'b0;
    endtask

    task automatic finish_test;
        $display("Errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(5'(i < 7 ? 16 + i : 31), 8'h00);
        end
        @(posedge core_clk);
        #1;
        chk("idle drive", 16'h0000, {15'h0, data_oe});
        wr(5'h04, 8'h12); wr(5'h05, 8'h34); wr(5'h06, 8'h00); wr(5'h07, 8'h02);
        rd(5'h04, 8'h12); rd(5'h05, 8'h34); rd(5'h07, 8'h02);
        wr(5'h11, 8'h01); wr(5'h15, 8'h07); wr(5'h14, 8'h02);
        periph_xfer_request <= 4'h2;
        strobe(16'h1234, 3'b011, 1'b0, 1'b1);
        strobe(16'h1235, 3'b011, 1'b1, 1'b1);
        @(posedge core_clk);
        periph_xfer_request <= 4'h0;
        rd(5'h05, 8'h36); rd(5'h07, 8'h00);
        chk("irq", 16'h0000, {15'h0, irq_n_or_block_end_n});
        rd(5'h11, 8'h41);
        rd(5'h15, 8'h87);
        // Stretch steal, memory write, decrementing address
        wr(5'h08, 8'h01); wr(5'h09, 8'h00); wr(5'h0a, 8'h00); wr(5'h0b, 8'h01);
        wr(5'h12, 8'h0a); wr(5'h14, 8'h04);
        periph_xfer_request <= 4'h4;
        strobe(16'h0100, 3'b100, 1'b1, 1'b0);
        @(posedge core_clk);
        periph_xfer_request <= 4'h0;
        rd(5'h09, 8'hff); rd(5'h08, 8'h00);
        rd(5'h15, 8'h87);
        // Halt burst of three bytes on channel 0, chained to channel 3
        wr(5'h0c, 8'h40); wr(5'h0d, 8'h00); wr(5'h0e, 8'h00); wr(5'h0f, 8'h05);
        wr(5'h00, 8'h20); wr(5'h01, 8'h00); wr(5'h02, 8'h00); wr(5'h03, 8'h03);
        wr(5'h10, 8'h04); wr(5'h16, 8'h01); wr(5'h14, 8'h01);
        periph_xfer_request <= 4'h1;
        for (int i = 0; i < 3; i++) begin
            strobe(16'h2000 + 16'(i), 3'b000, i == 2, 1'b1);
            if (i < 2) begin
                @(posedge core_clk);
                #1;
                seen_halt = !halt_dma_request_n;
            end
        end
        @(posedge core_clk);
        periph_xfer_request <= 4'h0;
        rd(5'h00, 8'h40); rd(5'h01, 8'h00); rd(5'h03, 8'h05);
        rd(5'h10, 8'h44);
        finish_test();
    end

    initial begin
        repeat (6000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end
endmodule

// [dv/fcd_grant_model.sv]
// Processor grant source facing the controller, clocked by the bench
`timescale 1ns/1ps
module fcd_grant_model (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Requests in, grant out
    input  wire logic stretch_dma_request_n,
    input  wire logic halt_dma_request_n,
    output logic      bus_grant_in
);
    // Grant follows either request one cycle late, as a halt would
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_grant_in <= 1'b0;
        end else begin
            bus_grant_in <= !(stretch_dma_request_n &&
                              halt_dma_request_n);
        end
    end
endmodule

// [src/fcd_arbiter.sv]
// Fixed or rotating priority pick among four transfer requests
`timescale 1ns/1ps
module fcd_arbiter (
    // Requests
    input  wire logic [3:0] eligible,
    // Priority control
    input  wire logic       rotate,
    input  wire logic [1:0] last_ch,
    // Result
    output logic            win_valid,
    output logic [1:0]      win_ch
);
    // Search from a start channel upward, wrapping round
    function automatic logic [1:0] fcd_pick(input logic [3:0] req,
                                            input logic [1:0] start);
        logic [1:0] idx;
        logic [1:0] res;
        logic       found;
        idx   = start;
        res   = start;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (!found && req[idx]) begin
                res   = idx;
                found = 1'b1;
            end
            idx = idx + 2'h1;
        end
        return res;
    endfunction

    wire logic [1:0] start_ch = rotate ? last_ch + 2'h1 : 2'h0;

    assign win_valid = |eligible;
    assign win_ch    = fcd_pick(eligible, start_ch);
endmodule

// [src/fcd_chan.sv]
// One channel's address and byte count registers
`timescale 1ns/1ps
`include "fcd_regs.svh"
module fcd_chan (
    // Clock
    input  wire logic        core_clk,
    // Processor writes
    input  wire logic        wr_addr_hi,
    input  wire logic        wr_addr_lo,
    input  wire logic        wr_cnt_hi,
    input  wire logic        wr_cnt_lo,
    input  wire logic [7:0]  wdata,
    // Transfer updates
    input  wire logic        step,
    input  wire logic        dec,
    input  wire logic        load,
    input  wire logic [15:0] load_addr,
    input  wire logic [15:0] load_cnt,
    // Contents
    output logic [15:0]      addr,
    output logic [15:0]      cnt
);
    // Address and count keep their contents across reset
    logic [15:0] addr_ff;
    logic [15:0] cnt_ff;

    wire logic [15:0] addr_step = dec ? addr_ff - `FCD_WORD_ONE
                                      : addr_ff + `FCD_WORD_ONE;
    wire logic [15:0] nxt_addr =
        load       ? load_addr :
        step       ? addr_step :
        wr_addr_hi ? {wdata, addr_ff[7:0]} :
        wr_addr_lo ? {addr_ff[15:8], wdata} : addr_ff;
    wire logic [15:0] nxt_cnt =
        load      ? load_cnt :
        step      ? cnt_ff - `FCD_WORD_ONE :
        wr_cnt_hi ? {wdata, cnt_ff[7:0]} :
        wr_cnt_lo ? {cnt_ff[15:8], wdata} : cnt_ff;

    always_ff @(posedge core_clk) begin
        addr_ff <= nxt_addr;
        cnt_ff  <= nxt_cnt;
    end

    assign addr = addr_ff;
    assign cnt  = cnt_ff;
endmodule

// [src/fcd_dmac.sv]
// Four-channel byte-wide DMA controller core
`timescale 1ns/1ps
`include "fcd_regs.svh"
module fcd_dmac (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Processor data bus
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             data_oe,
    // Low address lines, register select or DMA address
    input  wire logic [4:0]  addr_lo_in,
    output logic [4:0]       addr_lo_out,
    output logic             addr_lo_oe,
    // High address lines
    output logic [10:0]      addr_hi_out,
    output logic             addr_hi_oe,
    // Read/write line
    input  wire logic        rw_in,
    output logic             rw_out,
    output logic             rw_oe,
    // Chip select in, channel select high bit out
    input  wire logic        select_n_or_chan_ack_sel_hi_in,
    output logic             select_n_or_chan_ack_sel_hi_out,
    output logic             select_n_or_chan_ack_sel_hi_oe,
    // Bus request and grant
    output logic             stretch_dma_request_n,
    output logic             halt_dma_request_n,
    input  wire logic        bus_grant_in,
    // Peripheral side
    input  wire logic [3:0]  periph_xfer_request,
    output logic             chan_ack_sel_lo,
    output logic             xfer_strobe,
    output logic             irq_n_or_block_end_n
);
    // ****************************************************************
    // State
    // ****************************************************************
    fcd_pkg::fcd_state_type state_ff;
    fcd_pkg::fcd_state_type nxt_state;
    logic [1:0]  cur_ff;
    logic [1:0]  nxt_cur;
    logic [3:0]  chcr_ff [4];
    logic [3:0]  done_ff;
    logic [3:0]  nxt_done;
    logic [3:0]  req_en_ff;
    logic        rotate_ff;
    logic [3:0]  irq_en_ff;
    logic [3:0]  irq_flag_ff;
    logic [3:0]  nxt_irq_flag;
    logic        chain_en_ff;
    logic [1:0]  chain_sel_ff;
    logic        two_ch_ff;
    logic [15:0] dma_addr_ff;
    logic [15:0] nxt_dma_addr;
    logic [7:0]  rd_data_ff;
    logic        rd_oe_ff;
    logic [15:0] addr_w [4];
    logic [15:0] cnt_w  [4];

    // ****************************************************************
    // Processor register access
    // ****************************************************************
    // Register access only while the core does not own the buses
    wire logic proc_mode = (state_ff == fcd_pkg::FCD_IDLE);
    wire logic selected  = proc_mode && !select_n_or_chan_ack_sel_hi_in;
    wire logic reg_wr    = selected && !rw_in;
    wire logic reg_rd    = selected && rw_in;

    wire logic [4:0] ofs      = addr_lo_in;
    wire logic       in_words = ofs < `FCD_OFS_WORD_LIMIT;
    wire logic [1:0] ofs_ch   = ofs[`FCD_OFS_CH_MSB:`FCD_OFS_CH_LSB];
    wire logic       ofs_cnt  = ofs[`FCD_OFS_IS_COUNT];
    wire logic       ofs_low  = ofs[`FCD_OFS_IS_LOW];
    wire logic       is_chcr  = (ofs[4:2] == `FCD_CHCR_GROUP);
    wire logic       is_pcr   = (ofs == `FCD_OFS_PCR);
    wire logic       is_icr   = (ofs == `FCD_OFS_ICR);
    wire logic       is_dcr   = (ofs == `FCD_OFS_DCR);
    wire logic [1:0] chcr_ch  = ofs[1:0];

    // Status read of a channel's control byte
    wire logic [7:0] chcr_rd  = {cur_busy(chcr_ch), done_ff[chcr_ch],
                                 2'h0, chcr_ff[chcr_ch]};
    wire logic [15:0] word_rd = ofs_cnt ? cnt_w[ofs_ch] : addr_w[ofs_ch];
    wire logic [7:0]  byte_rd = ofs_low ? word_rd[7:0] : word_rd[15:8];
    wire logic [7:0]  pcr_rd  = {rotate_ff, 3'h0, req_en_ff};
    wire logic [7:0]  icr_rd  = {|irq_flag_ff, 3'h0, irq_en_ff};
    wire logic [7:0]  dcr_rd  = {4'h0, two_ch_ff, chain_sel_ff,
                                 chain_en_ff};
    wire logic [7:0]  nxt_rd_data =
        in_words ? byte_rd :
        is_chcr  ? chcr_rd :
        is_pcr   ? pcr_rd  :
        is_icr   ? icr_rd  :
        is_dcr   ? dcr_rd  : `FCD_BYTE_RST;

    // Busy means this channel owns the current transfer
    function automatic logic cur_busy(input logic [1:0] ch);
        return (state_ff != fcd_pkg::FCD_IDLE) && (cur_ff == ch);
    endfunction

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic        win_valid;
    logic [1:0]  win_ch;
    wire  logic [3:0] ch_mask = two_ch_ff ? 4'h3 : 4'hf;
    logic [3:0]  eligible;

    // Zero count means nothing to move, so such a channel never asks
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            eligible[i] = periph_xfer_request[i] && req_en_ff[i] &&
                          ch_mask[i] &&
                          (cnt_w[i] != `FCD_WORD_ZERO);
        end
    end

    fcd_arbiter u_arb (
        .eligible  (eligible),
        .rotate    (rotate_ff),
        .last_ch   (cur_ff),
        .win_valid (win_valid),
        .win_ch    (win_ch)
    );

    // ****************************************************************
    // Transfer sequencing
    // ****************************************************************
    wire logic [3:0]  cur_ctrl  = chcr_ff[cur_ff];
    wire logic        cur_tsc   = cur_ctrl[`FCD_CHCR_TSC];
    wire logic        cur_burst = cur_ctrl[`FCD_CHCR_BURST] && !cur_tsc;
    wire logic [15:0] cur_cnt   = cnt_w[cur_ff];
    wire logic        in_xfer   = (state_ff == fcd_pkg::FCD_XFER);
    wire logic        last_byte = in_xfer &&
                                  (cur_cnt == `FCD_WORD_ONE);
    wire logic        chain_now = last_byte && chain_en_ff &&
                                  (cur_ff == chain_sel_ff);

    always_comb begin
        nxt_state    = state_ff;
        nxt_cur      = cur_ff;
        nxt_dma_addr = dma_addr_ff;
        case (state_ff)
            fcd_pkg::FCD_IDLE: begin
                if (win_valid) begin
                    nxt_cur   = win_ch;
                    nxt_state = fcd_pkg::FCD_REQ;
                end
            end
            fcd_pkg::FCD_REQ: begin
                if (bus_grant_in) begin
                    nxt_dma_addr = cur_addr_of(cur_ff);
                    nxt_state    = fcd_pkg::FCD_XFER;
                end
            end
            fcd_pkg::FCD_XFER: begin
                if (last_byte || !cur_burst) begin
                    nxt_state = fcd_pkg::FCD_IDLE;
                end else begin
                    nxt_state = fcd_pkg::FCD_BWAIT;
                end
            end
            fcd_pkg::FCD_BWAIT: begin
                if (periph_xfer_request[cur_ff] && bus_grant_in) begin
                    nxt_dma_addr = cur_addr_of(cur_ff);
                    nxt_state    = fcd_pkg::FCD_XFER;
                end
            end
            default: begin
                nxt_state = fcd_pkg::FCD_IDLE;
            end
        endcase
    end

    function automatic logic [15:0] cur_addr_of(input logic [1:0] ch);
        return addr_w[ch];
    endfunction

    // Done and interrupt flags: a new end wins over a clearing read
    always_comb begin
        nxt_done     = done_ff;
        nxt_irq_flag = irq_flag_ff;
        if (reg_rd && is_chcr) begin
            nxt_done[chcr_ch] = 1'b0;
        end
        if (reg_rd && is_icr) begin
            nxt_irq_flag = 4'h0;
        end
        if (last_byte) begin
            nxt_done[cur_ff] = 1'b1;
            if (irq_en_ff[cur_ff]) begin
                nxt_irq_flag[cur_ff] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= fcd_pkg::FCD_IDLE;
            cur_ff      <= 2'h0;
            done_ff     <= 4'h0;
            irq_flag_ff <= 4'h0;
            dma_addr_ff <= `FCD_WORD_ZERO;
            rd_data_ff  <= `FCD_BYTE_RST;
            rd_oe_ff    <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cur_ff      <= nxt_cur;
            done_ff     <= nxt_done;
            irq_flag_ff <= nxt_irq_flag;
            dma_addr_ff <= nxt_dma_addr;
            rd_data_ff  <= nxt_rd_data;
            rd_oe_ff    <= reg_rd;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                chcr_ff[i] <= `FCD_CTRL_RST;
            end
            req_en_ff    <= 4'h0;
            rotate_ff    <= 1'b0;
            irq_en_ff    <= 4'h0;
            chain_en_ff  <= 1'b0;
            chain_sel_ff <= 2'h0;
            two_ch_ff    <= 1'b0;
        end else if (reg_wr) begin
            if (is_chcr) begin
                chcr_ff[chcr_ch] <= data_in[3:0];
            end
            if (is_pcr) begin
                req_en_ff <= data_in[3:0];
                rotate_ff <= data_in[`FCD_PCR_ROTATE];
            end
            if (is_icr) begin
                irq_en_ff <= data_in[3:0];
            end
            if (is_dcr) begin
                chain_en_ff  <= data_in[`FCD_DCR_EN];
                chain_sel_ff <= data_in[`FCD_DCR_SEL_MSB:`FCD_DCR_SEL_LSB];
                two_ch_ff    <= data_in[`FCD_DCR_TWO_CH];
            end
        end
    end

    // ****************************************************************
    // Channel address and count registers
    // ****************************************************************
    for (genvar g = 0; g < 4; g++) begin : g_chan
        wire logic hit = reg_wr && in_words && (ofs_ch == g[1:0]);
        fcd_chan u_chan (
            .core_clk   (core_clk),
            .wr_addr_hi (hit && !ofs_cnt && !ofs_low),
            .wr_addr_lo (hit && !ofs_cnt && ofs_low),
            .wr_cnt_hi  (hit && ofs_cnt && !ofs_low),
            .wr_cnt_lo  (hit && ofs_cnt && ofs_low),
            .wdata      (data_in),
            .step       (in_xfer && (cur_ff == g[1:0])),
            .dec        (chcr_ff[g][`FCD_CHCR_DEC]),
            .load       (chain_now && (cur_ff == g[1:0])),
            .load_addr  (addr_w[3]),
            .load_cnt   (cnt_w[3]),
            .addr       (addr_w[g]),
            .cnt        (cnt_w[g])
        );
    end

    // ****************************************************************
    // Pins
    // ****************************************************************
    // Requests drop as soon as the byte starts; burst keeps halt low
    wire logic in_req   = (state_ff == fcd_pkg::FCD_REQ);
    wire logic in_bwait = (state_ff == fcd_pkg::FCD_BWAIT);

    assign stretch_dma_request_n = !(in_req && cur_tsc);
    // Burst keeps halt low through every byte but the last
    wire logic burst_hold = in_xfer && cur_burst && !last_byte;
    assign halt_dma_request_n    = !((in_req && !cur_tsc) || in_bwait ||
                                     burst_hold);

    assign data_out    = rd_data_ff;
    assign data_oe     = rd_oe_ff && proc_mode;
    assign addr_lo_out = dma_addr_ff[4:0];
    assign addr_lo_oe  = in_xfer;
    assign addr_hi_out = dma_addr_ff[15:5];
    assign addr_hi_oe  = in_xfer;
    assign rw_out      = in_xfer && cur_ctrl[`FCD_CHCR_DIR];
    assign rw_oe       = in_xfer;
    assign xfer_strobe = in_xfer;

    assign chan_ack_sel_lo = in_xfer && cur_ff[0];
    assign select_n_or_chan_ack_sel_hi_out = cur_ff[1];
    assign select_n_or_chan_ack_sel_hi_oe  = in_xfer && !two_ch_ff;

    // Low during the final byte, then held while an interrupt is pending
    assign irq_n_or_block_end_n = !(last_byte ||
                                    (|irq_flag_ff));

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    strobe_after_grant_a: assert property (
        $rose(xfer_strobe) |-> $past(bus_grant_in) && !proc_mode)
        else $error("strobe without a preceding grant");
    steal_one_byte_a: assert property (
        xfer_strobe && !cur_burst |=> !xfer_strobe ##1 1'b1)
        else $error("steal mode moved more than one byte");
    data_off_dma_a: assert property (
        !proc_mode |-> !data_oe)
        else $error("data drivers on outside a register read");
    select_pin_out_a: assert property (
        select_n_or_chan_ack_sel_hi_oe |-> xfer_strobe && !two_ch_ff)
        else $error("select pin driven outside four-channel DMA");
    dma_dir_addr_a: assert property (
        $rose(xfer_strobe) |-> addr_lo_oe &&
            rw_out == chcr_ff[cur_ff][`FCD_CHCR_DIR] &&
            {addr_hi_out, addr_lo_out} == addr_w[cur_ff])
        else $error("DMA address or direction wrong");
    stretch_release_a: assert property (
        in_req && cur_tsc && !bus_grant_in |=>
            !stretch_dma_request_n || xfer_strobe)
        else $error("stretch request dropped before transfer");
    burst_halted_a: assert property (
        xfer_strobe && cur_burst && !last_byte |=>
            !halt_dma_request_n && !proc_mode)
        else $error("burst released the processor early");
    count_step_a: assert property (
        xfer_strobe && !chain_now |=>
            cur_cnt == $past(cur_cnt) - `FCD_WORD_ONE)
        else $error("byte count did not step by one");
    end_irq_a: assert property (
        last_byte && irq_en_ff[cur_ff] |=> !irq_n_or_block_end_n)
        else $error("interrupt missing after final byte");
    chain_reload_a: assert property (
        chain_now |=> cnt_w[$past(cur_ff)] == $past(cnt_w[3]))
        else $error("chained channel not reloaded");

    burst_done_c: cover property (
        xfer_strobe && cur_burst ##1 in_bwait ##[1:20] last_byte);
    tsc_steal_c: cover property (
        !stretch_dma_request_n ##[1:10] xfer_strobe);
    chain_c: cover property (chain_now);
endmodule

// [src/fcd_pkg.sv]
// Types shared by the DMA controller modules
package fcd_pkg;
    typedef enum logic [1:0] {
        FCD_IDLE,
        FCD_REQ,
        FCD_XFER,
        FCD_BWAIT
    } fcd_state_type;
endpackage

// [src/fcd_regs.svh]
// Register offsets, field positions and reset values of the DMA controller
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH

// ****************************************************************
// Register offsets on the five processor address lines
// ****************************************************************
`define FCD_OFS_WORD_LIMIT 5'h10
`define FCD_OFS_CHCR_BASE  5'h10
`define FCD_OFS_PCR        5'h14
`define FCD_OFS_ICR        5'h15
`define FCD_OFS_DCR        5'h16
`define FCD_CHCR_GROUP     3'h4

// ****************************************************************
// Offset bits inside the address/count block
// ****************************************************************
`define FCD_OFS_CH_MSB     3
`define FCD_OFS_CH_LSB     2
`define FCD_OFS_IS_COUNT   1
`define FCD_OFS_IS_LOW     0

// ****************************************************************
// Channel control fields
// ****************************************************************
`define FCD_CHCR_DIR       0
`define FCD_CHCR_TSC       1
`define FCD_CHCR_BURST     2
`define FCD_CHCR_DEC       3
`define FCD_CHCR_DONE      6
`define FCD_CHCR_BUSY      7

// ****************************************************************
// General control fields
// ****************************************************************
`define FCD_PCR_ROTATE     7
`define FCD_ICR_FLAG       7
`define FCD_DCR_EN         0
`define FCD_DCR_SEL_LSB    1
`define FCD_DCR_SEL_MSB    2
`define FCD_DCR_TWO_CH     3

// ****************************************************************
// Reset values and word constants
// ****************************************************************
`define FCD_CTRL_RST       4'h0
`define FCD_BYTE_RST       8'h00
`define FCD_WORD_ZERO      16'h0000
`define FCD_WORD_ONE       16'h0001

`endif
